/* verilog/eeprom_ctrl_map.svh */
`ifndef EEPROM_CTRL_MAP_SVH
`define EEPROM_CTRL_MAP_SVH

// Command opcodes received as the first byte of a frame.
`define OP_SET_WRITE_LATCH   8'h06
`define OP_CLEAR_WRITE_LATCH 8'h04
`define OP_READ_STATUS       8'h05
`define OP_WRITE_STATUS      8'h01
`define OP_READ_MEMORY       8'h03
`define OP_WRITE_MEMORY      8'h02

// Status bits that a status write may change (bits 7, 6, 4, 3 and 2).
`define STATUS_WRITE_MASK    8'hDC
// Status value after power-on: writes disabled, nothing protected.
`define STATUS_RESET         8'h00

// Frame length landmarks, counted in whole bytes.
`define FRAME_CMD_BYTES      6'h01
`define FRAME_WSR_BYTES      6'h02
`define FRAME_HDR_BYTES      6'h03
`define FRAME_BYTES_MAX      6'h3F

// Page geometry: 32-byte pages, five low address bits select the byte.
`define PAGE_BYTES           32
`define PAGE_IDX_BITS        5
`define PAGE_IDX_LAST        5'h1F

// Self-timed write cycle and the core clock period, both in ns.
`define T_WRITE_CYCLE_NS     4000000
`define CORE_CLK_PERIOD_NS   20

// Default number of significant array address bits.
`define ARRAY_ADDR_BITS      13

`endif

/* verilog/eeprom_ctrl_pkg.sv */
package eeprom_ctrl_pkg;

	// Status/control register view, bit 7 first.
	typedef struct packed {
		logic hw_protect_arm;
		logic id_page_select;
		logic zero_bit;
		logic id_page_lock;
		logic protect_sel_hi;
		logic protect_sel_lo;
		logic write_enable_latch;
		logic write_in_progress;
	} status_s;

	// One byte handed to the non-volatile array during programming.
	typedef struct packed {
		logic        id_page;
		logic [15:0] addr;
		logic [7:0]  data;
	} mem_wr_s;

	// Programming sequencer states in the core domain.
	typedef enum logic [1:0] {
		PS_IDLE  = 2'b00,
		PS_DRAIN = 2'b01,
		PS_WAIT  = 2'b10
	} prog_state_e;

endpackage

/* verilog/serial_eeprom_status_write_ctrl.sv */
// Functional notes
// - Busy flag high during programming, host cannot write.
// - Set-latch sets, clear-latch clears write enable.
// - Block selectors kept, changed only by status write.
// - Selectors protect none, quarter, half, all.
// - Pin low with arm bit blocks status writes.
// - Latch clear refuses all; status gated by pin.
// - Select bit routes accesses to identification page.
// - Select bit clears after read or write finishes.
// - Lock bit sticky, page then read-only until reset.
// - Setting select and lock together changes neither.
// - Status bit order fixed, bit five reads zero.
// - Power-up write-disabled, writes need latch, unprotected.
// - Latch sets only if frame ends after opcode.
// - Opcode, sixteen address clocks, density-masked address bits.
// - Programming starts at select rise; busy ignores all commands but status read.
// - Up to 32 bytes, index wraps within page.
// - Latch clears when internal write cycle completes.
// - Identification page uses address bits four to zero.
// - Page write refused if protected, full, or locked.
// - Six eight-bit opcodes decoded, others ignored.
// - Status write changes bits 2,3,4,6,7 only.
// - Pin fall during frame aborts status write.
// - Unknown opcode ignored, output stays released.
`include "eeprom_ctrl_map.svh"
`timescale 1ns/1ps
`default_nettype none

module serial_eeprom_status_write_ctrl #(
	parameter int          ADDR_BITS    = `ARRAY_ADDR_BITS,
	parameter int unsigned WRITE_CYCLES = `T_WRITE_CYCLE_NS / `CORE_CLK_PERIOD_NS
) (
	input  wire logic                    core_clk_i,
	input  wire logic                    sys_rst_i,
	input  wire logic                    spi_clk_i,
	input  wire logic                    cs_n_i,
	input  wire logic                    si_i,
	input  wire logic                    wp_n_i,
	output logic                         so_o,
	output logic                         so_oe_o,
	output logic                         mem_we_o,
	output eeprom_ctrl_pkg::mem_wr_s     mem_wr_o,
	output eeprom_ctrl_pkg::status_s     status_o
);

	// Width of the write cycle timer, sized from the cycle count.
	localparam int TW = $clog2(WRITE_CYCLES + 1);
	// Mask keeping only the significant array address bits.
	localparam logic [15:0] ADDR_MASK = 16'((32'h1 << ADDR_BITS) - 32'h1);

	// Tells whether an address falls inside the selected protected region.
	function automatic logic is_protected(input logic [15:0] a, input logic [1:0] sel);
		logic [1:0] quarter;
		quarter = a[ADDR_BITS-1 -: 2];
		unique case (sel)
			2'b00: is_protected = 1'b0;
			2'b01: is_protected = (quarter == 2'b11);
			2'b10: is_protected = quarter[1];
			2'b11: is_protected = 1'b1;
		endcase
	endfunction

	// ---------------------------------------------------------------
	// Link domain: everything below runs on the serial clock.
	// ---------------------------------------------------------------

	// The frame counters restart whenever chip select is high.
	wire          frame_rst = sys_rst_i | cs_n_i;
	logic [2:0]   bitc;          // Bit position within the current byte.
	logic         started;       // High after the first clock of a frame.
	logic [6:0]   sh;            // Incoming bits of the byte in flight.
	logic         rd_stat;       // Frame is a status read.
	logic [7:0]   stat_sh;       // Status bits being shifted out.
	logic         so_q;          // Output bit, changed on falling edges.
	logic         so_en_q;       // Output enable, changed on falling edges.

	// Frame results kept after chip select rises, for the core to read.
	logic [5:0]   res_bytes;     // Whole bytes received, saturating.
	logic         res_aligned;   // Frame ended exactly on a byte boundary.
	logic [7:0]   res_op;        // Opcode of the last frame.
	logic         res_busy;      // Device was busy when the opcode arrived.
	logic [7:0]   res_wsr;       // Status byte of a status write.
	logic [15:0]  res_addr;      // Address of a memory frame.
	logic [4:0]   res_idx;       // Rolling byte index within the page.
	logic [31:0]  res_mask;      // Page bytes loaded in this frame.
	logic [7:0]   page_buf [`PAGE_BYTES];

	// Status mirrored into this domain through two flip-flops.
	logic [7:0]   stat_meta;
	logic [7:0]   stat_sync;

	wire  [7:0]   rx_byte   = {sh, si_i};
	wire          byte_done = (bitc == 3'h7);
	wire  [5:0]   cur_bytes = started ? res_bytes : 6'h00;
	wire  [5:0]   next_bytes = (byte_done && cur_bytes != `FRAME_BYTES_MAX) ?
	                           6'(cur_bytes + 6'h01) : cur_bytes;
	// Data bytes are taken only by a write frame that began while idle.
	wire          data_phase = byte_done && (cur_bytes >= `FRAME_HDR_BYTES);
	wire          take_data  = data_phase && (res_op == `OP_WRITE_MEMORY) && !res_busy;

	// Input shifting and bit counting; chip select high clears them.
	always_ff @(posedge spi_clk_i or posedge frame_rst) begin
		if (frame_rst) begin
			bitc    <= 3'h0;
			started <= 1'b0;
			sh      <= 7'h00;
		end else begin
			bitc    <= 3'(bitc + 3'h1);
			started <= 1'b1;
			sh      <= {sh[5:0], si_i};
		end
	end

	// Status read recognition and output shifting.
	always_ff @(posedge spi_clk_i or posedge frame_rst) begin
		if (frame_rst) begin
			rd_stat <= 1'b0;
			stat_sh <= 8'h00;
		end else begin
			// Only a recognised status read opens the output.
			if (byte_done && cur_bytes == 6'h00 && rx_byte == `OP_READ_STATUS) begin
				rd_stat <= 1'b1;
			end
			// Reload every byte so that polling sees fresh busy state.
			if (byte_done) begin
				stat_sh <= stat_sync;
			end else begin
				stat_sh <= {stat_sh[6:0], 1'b0};
			end
		end
	end

	// Output bit and enable change on falling edges for the host to sample.
	always_ff @(negedge spi_clk_i or posedge frame_rst) begin
		if (frame_rst) begin
			so_q    <= 1'b0;
			so_en_q <= 1'b0;
		end else begin
			so_q    <= stat_sh[7];
			so_en_q <= rd_stat;
		end
	end

	// Unknown opcodes never set rd_stat, so the output stays released.
	assign so_o    = so_q;
	assign so_oe_o = so_en_q & ~cs_n_i;

	// Frame results; these survive chip select and only the opcode of
	// a fresh idle write clears the loaded-byte mask, so a frame sent
	// while busy cannot disturb a page that is still being programmed.
	always_ff @(posedge spi_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			res_bytes   <= 6'h00;
			res_aligned <= 1'b0;
			res_op      <= 8'h00;
			res_busy    <= 1'b0;
			res_wsr     <= 8'h00;
			res_addr    <= 16'h0000;
			res_idx     <= 5'h00;
			res_mask    <= 32'h0000_0000;
		end else begin
			res_bytes   <= next_bytes;
			res_aligned <= byte_done;
			if (byte_done) begin
				unique case (cur_bytes)
					6'h00: begin
						res_op   <= rx_byte;
						res_busy <= stat_sync[0];
						if (rx_byte == `OP_WRITE_MEMORY && !stat_sync[0]) begin
							res_mask <= 32'h0000_0000;
						end
					end
					6'h01: begin
						res_addr[15:8] <= res_busy ? res_addr[15:8] : rx_byte;
						res_wsr        <= rx_byte;
					end
					6'h02: begin
						res_addr[7:0] <= res_busy ? res_addr[7:0] : rx_byte;
						res_idx       <= rx_byte[4:0];
					end
					default: begin
						// Index rolls over inside the page; page bits stay.
						if (take_data) begin
							res_mask[res_idx] <= 1'b1;
							res_idx           <= 5'(res_idx + 5'h01);
						end
					end
				endcase
			end
		end
	end

	// Page buffer; a plain memory, so it carries no reset.
	always_ff @(posedge spi_clk_i) begin
		if (take_data) begin
			page_buf[res_idx] <= rx_byte;
		end
	end

	// Status crossing into the link domain. Bits change only at frame ends
	// and at write cycle completion, so a skew of one serial clock between bits is harmless.
	always_ff @(posedge spi_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			stat_meta <= `STATUS_RESET;
			stat_sync <= `STATUS_RESET;
		end else begin
			stat_meta <= status_o;
			stat_sync <= stat_meta;
		end
	end

	// ---------------------------------------------------------------
	// Core domain: status register and programming sequencer.
	// ---------------------------------------------------------------

	logic         cs_meta, cs_sync, cs_prev;    // Chip select synchroniser.
	logic         wp_meta, wp_sync, wp_prev;    // Protect pin synchroniser.
	logic         wp_abort;                     // Pin fell inside this frame.
	eeprom_ctrl_pkg::status_s     st;           // Status/control register.
	eeprom_ctrl_pkg::prog_state_e state;
	logic [TW-1:0] timer;                        // Write cycle timer.
	logic [4:0]   drain_idx;                    // Page byte being handed out.
	logic         we_q;
	logic         arr_cycle;                    // Cycle programs the array; ends a page access.
	eeprom_ctrl_pkg::mem_wr_s     wr_q;

	// Frame end is seen once chip select has been synchronised; by then
	// the serial clock is idle and the link results are quiet.
	wire cs_rise = cs_sync & ~cs_prev;
	wire cs_fall = ~cs_sync & cs_prev;
	wire wp_fall = ~wp_sync & wp_prev;

	// Frame decode; set-latch and clear-latch need a frame of exactly one byte.
	wire op_cmd_set_write_latch  = (res_op == `OP_SET_WRITE_LATCH) &&
	                (res_bytes == `FRAME_CMD_BYTES) && res_aligned;
	wire op_cmd_clear_write_latch  = (res_op == `OP_CLEAR_WRITE_LATCH) &&
	                (res_bytes == `FRAME_CMD_BYTES) && res_aligned;
	wire op_cmd_write_status  = (res_op == `OP_WRITE_STATUS) &&
	                (res_bytes == `FRAME_WSR_BYTES) && res_aligned;
	wire op_write = (res_op == `OP_WRITE_MEMORY) &&
	                (res_bytes > `FRAME_HDR_BYTES) && res_aligned;
	wire op_read  = (res_op == `OP_READ_MEMORY) && (res_bytes >= `FRAME_HDR_BYTES);

	// Target address: page index only for the identification page,
	// density-masked for the main array.
	wire [15:0] id_addr   = {11'h000, res_addr[4:0]};
	wire [15:0] arr_addr  = res_addr & ADDR_MASK;
	wire [15:0] chk_addr  = st.id_page_select ? id_addr : arr_addr;
	wire [1:0]  prot_sel  = {st.protect_sel_hi, st.protect_sel_lo};
	wire        prot_hit  = is_protected(chk_addr, prot_sel);
	wire        hw_lock   = st.hw_protect_arm & ~wp_sync;
	wire        id_locked = st.id_page_select & st.id_page_lock;

	// Protected blocks are refused whatever the pin says.
	wire wr_allow  = st.write_enable_latch & ~prot_hit & ~id_locked;
	wire wsr_allow = st.write_enable_latch & ~hw_lock & ~wp_abort;

	// Incoming status byte restricted to writable bits.
	wire [7:0] wsr_bits = (res_wsr & `STATUS_WRITE_MASK) |
	                      (status_o & ~`STATUS_WRITE_MASK);
	eeprom_ctrl_pkg::status_s wsr_in;
	assign wsr_in = eeprom_ctrl_pkg::status_s'(wsr_bits);
	wire both_set = wsr_in.id_page_select & wsr_in.id_page_lock;

	wire idle_free = (state == eeprom_ctrl_pkg::PS_IDLE) && !st.write_in_progress;
	wire cycle_end = (timer == TW'(WRITE_CYCLES - 1));

	// Two-flop synchronisers for the pins, plus a delayed copy for edges.
	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			cs_meta <= 1'b1;
			cs_sync <= 1'b1;
			cs_prev <= 1'b1;
			wp_meta <= 1'b1;
			wp_sync <= 1'b1;
			wp_prev <= 1'b1;
		end else begin
			cs_meta <= cs_n_i;
			cs_sync <= cs_meta;
			cs_prev <= cs_sync;
			wp_meta <= wp_n_i;
			wp_sync <= wp_meta;
			wp_prev <= wp_sync;
		end
	end

	// Pin fall while selected cancels a pending status write; a fall in
	// the same cycle as the select fall still counts.
	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			wp_abort <= 1'b0;
		end else if (wp_fall && !cs_sync) begin
			wp_abort <= 1'b1;
		end else if (cs_fall) begin
			wp_abort <= 1'b0;
		end
	end

	// Status register and sequencer. The register resets to a
	// write-disabled, unprotected state; non-volatile bits are held in
	// flip-flops here only, and reset returns them to that state.
	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			st        <= eeprom_ctrl_pkg::status_s'(`STATUS_RESET);
			state     <= eeprom_ctrl_pkg::PS_IDLE;
			timer     <= '0;
			arr_cycle <= 1'b0;
			drain_idx <= 5'h00;
		end else begin
			unique case (state)
				eeprom_ctrl_pkg::PS_IDLE: begin
					// While busy nothing is committed; only status reads work.
					if (cs_rise && idle_free) begin
						if (op_cmd_set_write_latch) begin
							st.write_enable_latch <= 1'b1;
						end else if (op_cmd_clear_write_latch) begin
							st.write_enable_latch <= 1'b0;
						end else if (op_cmd_write_status && wsr_allow) begin
							// Selectors and arm bit change only here.
							st.hw_protect_arm    <= wsr_in.hw_protect_arm;
							st.protect_sel_hi    <= wsr_in.protect_sel_hi;
							st.protect_sel_lo    <= wsr_in.protect_sel_lo;
							if (!both_set) begin
								st.id_page_select <= wsr_in.id_page_select;
								st.id_page_lock   <= st.id_page_lock | wsr_in.id_page_lock;
							end
							st.write_in_progress <= 1'b1;
							arr_cycle            <= 1'b0;
							timer                <= '0;
							state                <= eeprom_ctrl_pkg::PS_WAIT;
						end else if (op_write && wr_allow) begin
							st.write_in_progress <= 1'b1;
							drain_idx            <= 5'h00;
							arr_cycle            <= 1'b1;
							state                <= eeprom_ctrl_pkg::PS_DRAIN;
						end else if (op_read || op_write) begin
							// A finished read, or a refused write, ends the page access.
							st.id_page_select <= 1'b0;
						end
					end
				end
				eeprom_ctrl_pkg::PS_DRAIN: begin
					// One page slot per cycle, then the self-timed wait.
					drain_idx <= 5'(drain_idx + 5'h01);
					if (drain_idx == `PAGE_IDX_LAST) begin
						timer <= '0;
						state <= eeprom_ctrl_pkg::PS_WAIT;
					end
				end
				eeprom_ctrl_pkg::PS_WAIT: begin
					timer <= TW'(timer + 1'b1);
					if (cycle_end) begin
						st.write_in_progress  <= 1'b0;
						st.write_enable_latch <= 1'b0;
						st.id_page_select     <= st.id_page_select & ~arr_cycle;
						state                 <= eeprom_ctrl_pkg::PS_IDLE;
					end
				end
				default: begin
					state <= eeprom_ctrl_pkg::PS_IDLE;
				end
			endcase
		end
	end

	// Byte hand-off to the array: only loaded slots are written, at the
	// page address with the index substituted in the low bits.
	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			we_q <= 1'b0;
			wr_q <= '0;
		end else begin
			we_q         <= (state == eeprom_ctrl_pkg::PS_DRAIN) && res_mask[drain_idx];
			wr_q.id_page <= st.id_page_select;
			wr_q.addr    <= st.id_page_select ? {11'h000, drain_idx} :
			                ({res_addr[15:5], drain_idx} & ADDR_MASK);
			wr_q.data    <= page_buf[drain_idx];
		end
	end

	assign mem_we_o = we_q;
	assign mem_wr_o = wr_q;

	// Bit 5 always reads zero; host writes never reach the busy bit.
	always_comb begin
		status_o          = st;
		status_o.zero_bit = 1'b0;
	end

endmodule

`default_nettype wire

/* testbench/status_write_checker_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
// Watches the top-level ports and checks the write-control rules on the core clock.
module status_write_checker #(
	parameter int          ADDR_BITS    = 13,
	parameter int unsigned WRITE_CYCLES = 50
) (
	input  wire logic                     core_clk_i,
	input  wire logic                     sys_rst_i,
	input  wire logic                     spi_clk_i,
	input  wire logic                     cs_n_i,
	input  wire logic                     si_i,
	input  wire logic                     wp_n_i,
	input  wire logic                     so_o,
	input  wire logic                     so_oe_o,
	input  wire logic                     mem_we_o,
	input  wire eeprom_ctrl_pkg::mem_wr_s mem_wr_o,
	input  wire eeprom_ctrl_pkg::status_s status_o
);
	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (sys_rst_i);
	localparam int MIN_BUSY = WRITE_CYCLES - 1; // One cycle of slack; busy_cnt reaches WRITE_CYCLES for a status write.
	logic [31:0] busy_cnt; // Length of the current busy stretch.
	logic [1:0]  top2;     // Two most significant array address bits.
	logic        page_wr;  // An array byte was handed out in this busy stretch.
	logic        in_prot;  // Main-array address lies in the selected region.
	assign top2    = mem_wr_o.addr[ADDR_BITS-1 -: 2];
	assign in_prot = (status_o.protect_sel_hi & status_o.protect_sel_lo)
		| (status_o.protect_sel_hi & ~status_o.protect_sel_lo & top2[1])
		| (~status_o.protect_sel_hi & status_o.protect_sel_lo & (&top2));
	// Counts busy cycles so that a shortened write cycle shows up.
	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			busy_cnt <= '0;
			page_wr  <= 1'b0;
		end else begin
			busy_cnt <= status_o.write_in_progress ? busy_cnt + 1 : '0;
			page_wr  <= status_o.write_in_progress & (page_wr | mem_we_o);
		end
	end
	a_busy_length: assert property ($fell(status_o.write_in_progress) |-> busy_cnt >= MIN_BUSY)
		else $error("busy flag dropped early");
	a_latch_end: assert property ($fell(status_o.write_in_progress) |-> !status_o.write_enable_latch)
		else $error("write latch kept after write");
	a_select_end: assert property ($fell(status_o.write_in_progress) && page_wr |-> !status_o.id_page_select)
		else $error("page select kept after write");
	a_zero_bit: assert property (status_o.zero_bit == 1'b0)
		else $error("constant status bit not zero");
	a_lock_sticky: assert property (!$fell(status_o.id_page_lock))
		else $error("page lock cleared");
	a_sel_lock_excl: assert property (!($rose(status_o.id_page_select) && $rose(status_o.id_page_lock)))
		else $error("select and lock set together");
	a_start_latched: assert property ($rose(status_o.write_in_progress) |-> status_o.write_enable_latch)
		else $error("write started without latch");
	a_we_busy: assert property (mem_we_o |-> status_o.write_in_progress)
		else $error("array write outside busy");
	a_prot_region: assert property (mem_we_o && !mem_wr_o.id_page |-> !in_prot)
		else $error("write into protected region");
	a_page_guard: assert property (mem_we_o && mem_wr_o.id_page |-> !status_o.id_page_lock
		&& !(status_o.protect_sel_hi && status_o.protect_sel_lo))
		else $error("locked page written");
	a_so_released: assert property (cs_n_i |-> !so_oe_o)
		else $error("output driven while deselected");
	c_array_write: cover property (mem_we_o && !mem_wr_o.id_page);
	c_page_write: cover property (mem_we_o && mem_wr_o.id_page);
	c_status_done: cover property ($fell(status_o.write_in_progress));
endmodule
bind serial_eeprom_status_write_ctrl status_write_checker #(
	.ADDR_BITS   (ADDR_BITS),
	.WRITE_CYCLES(WRITE_CYCLES)
) chk (
	.core_clk_i(core_clk_i),
	.sys_rst_i (sys_rst_i),
	.spi_clk_i (spi_clk_i),
	.cs_n_i    (cs_n_i),
	.si_i      (si_i),
	.wp_n_i    (wp_n_i),
	.so_o      (so_o),
	.so_oe_o   (so_oe_o),
	.mem_we_o  (mem_we_o),
	.mem_wr_o  (mem_wr_o),
	.status_o  (status_o)
);
`default_nettype wire

/* testbench/spi_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Behavioural serial master, mode 0, 125 ns clock that stands still between frames.
module spi_host_model (
	output logic      spi_clk_o,
	output logic      cs_n_o,
	output logic      si_o,
	input  wire logic so_i
);
	logic [7:0] rx; // Last eight bits seen on the serial output.
	// Idle state: deselected, clock low.
	initial begin
		spi_clk_o = 1'b0;
		cs_n_o = 1'b1;
		si_o = 1'b0;
		rx = 8'h00;
	end
	// Sends the low nb bits of v, most significant first, and ends the frame cleanly.
	task automatic frame(input logic [39:0] v, input int nb);
		cs_n_o = 1'b0;
		#62.5;
		for (int i = nb - 1; i >= 0; i--) begin
			si_o = v[i];
			#62.5;
			spi_clk_o = 1'b1;
			rx = {rx[6:0], so_i};
			#62.5;
			spi_clk_o = 1'b0;
		end
		#62.5;
		cs_n_o = 1'b1;
		si_o = ~si_o; // Undriven-looking data line between frames, so no stale bit helps.
		#250; // Deselect time well over four core cycles.
	endtask
endmodule
`default_nettype wire

/* testbench/tb_serial_eeprom_status_write_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
// Self-checking bench: status and array writes with protection, page select and lock.
module tb_serial_eeprom_status_write_ctrl;
	localparam int          AB = 10;  // Smallest density, 1 KB array.
	localparam int unsigned WC = 400; // Shortened write cycle in core clocks.
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic wp_n = 1'b1;
	logic spi_clk, cs_n, si, so, so_oe, mem_we;
	logic [7:0] d0, d1; // Random data bytes.
	eeprom_ctrl_pkg::mem_wr_s mem_wr;
	eeprom_ctrl_pkg::status_s st;
	eeprom_ctrl_pkg::mem_wr_s exp_q[$]; // Expected array writes, oldest first.
	int fails = 0;
	int n_compared = 0;
	int cyc = 0;
	logic oe_seen = 1'b0; // Output enable seen high since last cleared.
	always #10 core_clk = ~core_clk;
	serial_eeprom_status_write_ctrl #(.ADDR_BITS(AB), .WRITE_CYCLES(WC)) dut (
		.core_clk_i(core_clk), .sys_rst_i(rst), .spi_clk_i(spi_clk), .cs_n_i(cs_n),
		.si_i(si), .wp_n_i(wp_n), .so_o(so), .so_oe_o(so_oe), .mem_we_o(mem_we),
		.mem_wr_o(mem_wr), .status_o(st));
	spi_host_model host (.spi_clk_o(spi_clk), .cs_n_o(cs_n), .si_o(si), .so_i(so));
	task automatic cmp8(input string what, input logic [7:0] e, input logic [7:0] s);
		n_compared++;
		if (s !== e) begin
			fails++;
			$display("BAD %s expected %h seen %h", what, e, s);
		end
	endtask
	task automatic cmp_wr(input logic [24:0] e, input logic [24:0] s);
		n_compared++;
		if (s !== e) begin
			fails++;
			$display("BAD mem_wr expected %h seen %h", e, s);
		end
	endtask
	task automatic give_verdict;
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// Waits out any programming cycle under a bound.
	task automatic settle;
		repeat (8) @(negedge core_clk);
		for (int i = 0; i < 1000 && st.write_in_progress !== 1'b0; i++) @(negedge core_clk);
	endtask
	// Set-latch frame, then a status write frame.
	task automatic wsr(input logic [7:0] v);
		host.frame({32'h0, 8'h06}, 8);
		host.frame({24'h0, 8'h01, v}, 16);
	endtask
	// Each array write pulse takes the oldest expected write off the queue.
	always @(negedge core_clk) begin
		if (mem_we === 1'b1) begin
			if (exp_q.size() == 0) begin
				fails++;
				$display("BAD mem_we expected 0 seen 1");
			end else begin
				cmp_wr(exp_q.pop_front(), mem_wr);
			end
		end
	end
	// Notes any driven output while the host clocks a frame.
	always @(posedge spi_clk) begin
		if (so_oe === 1'b1) begin
			oe_seen = 1'b1;
		end
	end
	// Cuts a hang short.
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 30000) begin
			fails++;
			give_verdict();
		end
	end
	initial begin
		void'($urandom(82));
		repeat (12) @(negedge core_clk);
		rst = 1'b0;
		repeat (2) @(negedge core_clk);
		cmp8("status", 8'h00, st);
		host.frame({24'h0, 16'h018C}, 16);
		settle();
		cmp8("status", 8'h00, st);
		host.frame({32'h0, 8'h06}, 8);
		cmp8("status", 8'h02, st);
		host.frame({32'h0, 8'h04}, 8);
		cmp8("status", 8'h00, st);
		host.frame({24'h0, 16'h0600}, 16);
		cmp8("status", 8'h00, st);
		oe_seen = 1'b0;
		host.frame({24'h0, 16'hA500}, 16);
		cmp8("output enable", 8'h00, 8'(oe_seen));
		cmp8("status", 8'h00, st);
		$display("test latch done");
		wsr(8'hFF);
		cmp8("status", 8'h8F, st);
		oe_seen = 1'b0;
		host.frame({24'h0, 16'h0500}, 16);
		cmp8("status read", 8'h8F, host.rx);
		cmp8("output enable", 8'h01, 8'(oe_seen));
		settle();
		cmp8("status", 8'h8C, st);
		@(negedge core_clk) wp_n = 1'b0;
		wsr(8'h04);
		settle();
		cmp8("status", 8'h8E, st);
		@(negedge core_clk) wp_n = 1'b1;
		wsr(8'h04);
		settle();
		cmp8("status", 8'h04, st);
		host.frame({32'h0, 8'h06}, 8);
		fork
			host.frame({24'h0, 16'h0108}, 16);
			begin
				#1000;
				@(negedge core_clk) wp_n = 1'b0;
			end
		join
		settle();
		cmp8("status", 8'h06, st);
		@(negedge core_clk) wp_n = 1'b1;
		$display("test status write done");
		host.frame({8'h0, 8'h02, 16'hFF1E, 8'h5A}, 32);
		settle();
		cmp8("status", 8'h06, st);
		d0 = 8'($urandom());
		d1 = 8'($urandom());
		exp_q.push_back({1'b0, 16'h0000, d1});
		exp_q.push_back({1'b0, 16'h001F, d0});
		host.frame({8'h02, 16'hFC1F, d0, d1}, 40);
		cmp8("status", 8'h07, st);
		settle();
		cmp8("status", 8'h04, st);
		$display("test array write done");
		wsr(8'h44);
		settle();
		cmp8("status", 8'h44, st);
		exp_q.push_back({1'b1, 16'h0003, d0});
		host.frame({32'h0, 8'h06}, 8);
		host.frame({8'h0, 8'h02, 16'hFFE3, d0}, 32);
		settle();
		cmp8("status", 8'h04, st);
		wsr(8'h14);
		settle();
		cmp8("status", 8'h14, st);
		wsr(8'h44);
		settle();
		host.frame({32'h0, 8'h06}, 8);
		host.frame({8'h0, 8'h02, 16'h0003, d1}, 32);
		settle();
		cmp8("status", 8'h16, st);
		wsr(8'h04);
		settle();
		cmp8("status", 8'h14, st);
		wsr(8'h44);
		settle();
		cmp8("status", 8'h54, st);
		host.frame({8'h0, 8'h03, 16'h0000, 8'h00}, 32);
		cmp8("status", 8'h14, st);
		cmp8("pending writes", 8'h00, 8'(exp_q.size()));
		$display("test page done");
		give_verdict();
	end
endmodule
`default_nettype wire
